// file: rtl/ccr_pkg.sv
package ccr_pkg;
    // Register indices
    localparam logic [7:0]  ADDR_CH0_UPPER    = 8'h00;
    localparam logic [7:0]  ADDR_CH0_LOWER    = 8'h01;
    localparam logic [7:0]  ADDR_CH1_UPPER    = 8'h02;
    localparam logic [7:0]  ADDR_CH1_LOWER    = 8'h03;
    localparam logic [7:0]  ADDR_CH2_UPPER    = 8'h04;
    localparam logic [7:0]  ADDR_CH2_LOWER    = 8'h05;
    localparam logic [7:0]  ADDR_CH3_UPPER    = 8'h06;
    localparam logic [7:0]  ADDR_CH3_LOWER    = 8'h07;
    localparam logic [7:0]  ADDR_CH0_INTERVAL = 8'h08;
    // Field positions
    localparam int          WD_FLAG_BIT       = 13;
    localparam int          AW_FLAG_BIT       = 12;
    localparam int          UPPER_DATA_MSB    = 11;
    localparam int          RESULT_SPLIT      = 16;
    // Reference count reset value and minimum
    localparam logic [15:0] REF_COUNT_RESET   = 16'h0080;
    localparam logic [15:0] REF_COUNT_MIN     = 16'h0100;
    // Conversion time per reference count unit
    localparam int          CLKS_PER_COUNT    = 16;
    localparam logic [1:0]  VARIANT_12        = 2'h0;
    localparam logic [1:0]  VARIANT_28        = 2'h1;
endpackage

// file: rtl/ccr_result_regs.sv
`timescale 1ns/1ps
// Overview of operation
// - Watchdog flag at bit 13, clears on read.
// - Amplitude flag at bit 12, clears on read.
// - 12-bit variant: bits 11:0 hold result.
// - 28-bit variant: upper 27:16, lower 15:0.
// - Conversion lasts reference count times 16 clocks.
// - Reference count resets to 0x0080.
module ccr_result_regs #(
    parameter int          NUM_CH    = 4,
    parameter logic [1:0]  VARIANT   = ccr_pkg::VARIANT_28
) (
    input  wire logic              core_clk_i,
    input  wire logic              rst_i,
    input  wire logic              clk_en_i,
    input  wire logic              rd_i,
    input  wire logic              wr_i,
    input  wire logic [7:0]        addr_i,
    input  wire logic [15:0]       wdata_i,
    output logic [15:0]            rdata_o,
    input  wire logic [NUM_CH-1:0] conv_done_i,
    input  wire logic [NUM_CH-1:0] wd_fault_i,
    input  wire logic [NUM_CH-1:0] aw_fault_i,
    input  wire logic [27:0]       result_i [NUM_CH],
    output logic                   chan0_conv_end_o,
    output logic [15:0]            chan0_ref_count_o
);
    // ----------------------------------------
    // Parameter checks
    // ----------------------------------------
    // Only four result slots exist in the map
    if (NUM_CH < 1 || NUM_CH > 4) begin : g_bad_num_ch
        $error("NUM_CH must be 1..4");
    end
    if (VARIANT > ccr_pkg::VARIANT_28) begin : g_bad_variant
        $error("Unknown variant");
    end

    // ----------------------------------------
    // Storage
    // ----------------------------------------
    logic [27:0]       result_reg [NUM_CH];
    logic [27:0]       result_next [NUM_CH];
    logic [NUM_CH-1:0] wd_reg, wd_next, aw_reg, aw_next;
    logic [15:0]       lower_hold_reg [NUM_CH];
    logic [15:0]       lower_hold_next [NUM_CH];
    logic [15:0]       ref_count_reg, ref_count_next;
    logic [19:0]       conv_cnt_reg, conv_cnt_next;
    logic [15:0]       rdata_reg, rdata_next;
    logic              conv_end_reg, conv_end_next;

    function automatic logic is_upper(input logic [7:0] a, input int ch);
        return a == 8'((2 * ch) & 8'hff);
    endfunction

    // Interval length in clocks for a given reference count
    function automatic logic [19:0] conv_len(input logic [15:0] count);
        return 20'(32'(count) * ccr_pkg::CLKS_PER_COUNT);
    endfunction

    always_comb begin
        wd_next         = wd_reg;
        aw_next         = aw_reg;
        result_next     = result_reg;
        lower_hold_next = lower_hold_reg;
        ref_count_next  = ref_count_reg;
        rdata_next      = 16'h0000;
        conv_end_next   = 1'b0;
        // Conversion interval counter
        // count times sixteen
        // Reserved counts are not refused; zero wraps the limit
        if (conv_cnt_reg >= conv_len(ref_count_reg) - 20'h1) begin
            conv_cnt_next = 20'h0;
            conv_end_next = 1'b1;
        end else begin
            conv_cnt_next = conv_cnt_reg + 20'h1;
        end
        if (wr_i && addr_i == ccr_pkg::ADDR_CH0_INTERVAL) begin
            ref_count_next = wdata_i;
        end
        if (rd_i && addr_i == ccr_pkg::ADDR_CH0_INTERVAL) begin
            rdata_next = ref_count_reg;
        end
        for (int ch = 0; ch < NUM_CH; ch++) begin
            if (rd_i && is_upper(addr_i, ch)) begin
                rdata_next[ccr_pkg::WD_FLAG_BIT] = wd_reg[ch];
                rdata_next[ccr_pkg::AW_FLAG_BIT] = aw_reg[ch];
                if (VARIANT == ccr_pkg::VARIANT_28) begin
                    rdata_next[ccr_pkg::UPPER_DATA_MSB:0] = result_reg[ch][27:16];
                    lower_hold_next[ch] = result_reg[ch][15:0];
                end else begin
                    rdata_next[ccr_pkg::UPPER_DATA_MSB:0] = result_reg[ch][11:0];
                end
                wd_next[ch] = 1'b0;
                aw_next[ch] = 1'b0;
            end
            if (rd_i && VARIANT == ccr_pkg::VARIANT_28
                && addr_i == 8'((2 * ch + 1) & 8'hff)) begin
                rdata_next = lower_hold_reg[ch];
            end
            if (wd_fault_i[ch]) wd_next[ch] = 1'b1;
            if (aw_fault_i[ch]) aw_next[ch] = 1'b1;
            if (conv_done_i[ch]) result_next[ch] = result_i[ch];
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wd_reg        <= '0;
            aw_reg        <= '0;
            ref_count_reg <= ccr_pkg::REF_COUNT_RESET;
            conv_cnt_reg  <= 20'h0;
            rdata_reg     <= 16'h0000;
            conv_end_reg  <= 1'b0;
            for (int ch = 0; ch < NUM_CH; ch++) begin
                result_reg[ch]     <= 28'h0;
                lower_hold_reg[ch] <= 16'h0000;
            end
        end else if (clk_en_i) begin
            wd_reg         <= wd_next;
            aw_reg         <= aw_next;
            ref_count_reg  <= ref_count_next;
            conv_cnt_reg   <= conv_cnt_next;
            rdata_reg      <= rdata_next;
            conv_end_reg   <= conv_end_next;
            result_reg     <= result_next;
            lower_hold_reg <= lower_hold_next;
        end
    end

    assign rdata_o           = rdata_reg;
    assign chan0_conv_end_o  = conv_end_reg;
    assign chan0_ref_count_o = ref_count_reg;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    property p_wd_clear;
        @(posedge core_clk_i) disable iff (rst_i)
        (clk_en_i && rd_i && addr_i == ccr_pkg::ADDR_CH0_UPPER && !wd_fault_i[0])
            |=> !wd_reg[0];
    endproperty
    a_wd_clear: assert property (p_wd_clear) else $error("watchdog flag not cleared");

    property p_aw_clear;
        @(posedge core_clk_i) disable iff (rst_i)
        (clk_en_i && rd_i && addr_i == ccr_pkg::ADDR_CH0_UPPER && !aw_fault_i[0])
            |=> !aw_reg[0];
    endproperty
    a_aw_clear: assert property (p_aw_clear) else $error("amplitude flag not cleared");

    property p_wd_read;
        @(posedge core_clk_i) disable iff (rst_i)
        (clk_en_i && rd_i && addr_i == ccr_pkg::ADDR_CH0_UPPER)
            |=> rdata_o[ccr_pkg::WD_FLAG_BIT] == $past(wd_reg[0]);
    endproperty
    a_wd_read: assert property (p_wd_read) else $error("watchdog bit misplaced");

    property p_aw_read;
        @(posedge core_clk_i) disable iff (rst_i)
        (clk_en_i && rd_i && addr_i == ccr_pkg::ADDR_CH0_UPPER)
            |=> rdata_o[ccr_pkg::AW_FLAG_BIT] == $past(aw_reg[0]);
    endproperty
    a_aw_read: assert property (p_aw_read) else $error("amplitude bit misplaced");

    property p_upper_data;
        @(posedge core_clk_i) disable iff (rst_i)
        (clk_en_i && rd_i && addr_i == ccr_pkg::ADDR_CH0_UPPER)
            |=> rdata_o[11:0] == (VARIANT == ccr_pkg::VARIANT_28 ?
                $past(result_reg[0][27:16]) : $past(result_reg[0][11:0]));
    endproperty
    a_upper_data: assert property (p_upper_data) else $error("upper data wrong");

    property p_lower_data;
        @(posedge core_clk_i) disable iff (rst_i)
        (clk_en_i && rd_i && addr_i == ccr_pkg::ADDR_CH0_UPPER
         && VARIANT == ccr_pkg::VARIANT_28)
            |=> lower_hold_reg[0] == $past(result_reg[0][15:0]);
    endproperty
    a_lower_data: assert property (p_lower_data) else $error("lower snapshot wrong");

    property p_flag_sticky;
        @(posedge core_clk_i) disable iff (rst_i)
        (wd_reg[0] && !(rd_i && addr_i == ccr_pkg::ADDR_CH0_UPPER)) |=> wd_reg[0];
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped");

    property p_flag_set;
        @(posedge core_clk_i) disable iff (rst_i)
        (clk_en_i && aw_fault_i[0]) |=> aw_reg[0];
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("flag not set");

    property p_wd_set;
        @(posedge core_clk_i) disable iff (rst_i)
        (clk_en_i && wd_fault_i[0]) |=> wd_reg[0];
    endproperty
    a_wd_set: assert property (p_wd_set) else $error("watchdog flag not set");

    property p_conv_len;
        @(posedge core_clk_i) disable iff (rst_i)
        (clk_en_i && conv_end_next) |-> conv_cnt_reg == conv_len(ref_count_reg) - 20'h1;
    endproperty
    a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");

    // Independent interval timer, so the length check does not reuse the counter
    logic [19:0] gap_cnt_reg, gap_cnt_next;
    logic        gap_ok_reg, gap_ok_next;

    always_comb begin
        gap_cnt_next = gap_cnt_reg + 20'h1;
        gap_ok_next  = gap_ok_reg;
        if (conv_end_reg) begin
            gap_cnt_next = 20'h1;
            gap_ok_next  = 1'b1;
        end
        // A rewrite mid-interval voids the next length
        if (wr_i && addr_i == ccr_pkg::ADDR_CH0_INTERVAL) begin
            gap_ok_next = 1'b0;
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            gap_cnt_reg <= 20'h0;
            gap_ok_reg  <= 1'b0;
        end else if (clk_en_i) begin
            gap_cnt_reg <= gap_cnt_next;
            gap_ok_reg  <= gap_ok_next;
        end
    end

    property p_conv_gap;
        @(posedge core_clk_i) disable iff (rst_i)
        (clk_en_i && chan0_conv_end_o && gap_ok_reg) |-> gap_cnt_reg == conv_len(ref_count_reg);
    endproperty
    a_conv_gap: assert property (p_conv_gap) else $error("conversion interval wrong");

    property p_reset_count;
        @(posedge core_clk_i)
        $fell(rst_i) |-> ref_count_reg == ccr_pkg::REF_COUNT_RESET;
    endproperty
    a_reset_count: assert property (p_reset_count) else $error("bad reset count");
endmodule

// file: verification/ccr_host_model.sv
`timescale 1ns/1ps
module ccr_host_model (
    input  wire logic        core_clk_i,
    input  wire logic [15:0] rdata_i,
    input  wire logic [15:0] rdata12_i,
    output logic             rd_o,
    output logic             wr_o,
    output logic [7:0]       addr_o,
    output logic [15:0]      wdata_o
);
    initial begin
        rd_o    = 1'b0;
        wr_o    = 1'b0;
        addr_o  = 8'h00;
        wdata_o = 16'h0000;
    end
    // One-cycle strobe; the answer stands the cycle after
    task automatic rd(input logic [7:0] a, output logic [15:0] v, output logic [15:0] w);
        @(posedge core_clk_i);
        rd_o   <= 1'b1;
        addr_o <= a;
        @(posedge core_clk_i);
        rd_o   <= 1'b0;
        #1;
        v = rdata_i;
        w = rdata12_i;
    endtask
    task automatic rd_chan(input logic [7:0] a, output logic [15:0] v [4]);
        rd(a, v[0], v[1]);
        rd(a + 8'h01, v[2], v[3]);
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        if (a == ccr_pkg::ADDR_CH0_INTERVAL && d < ccr_pkg::REF_COUNT_MIN) begin
            d = ccr_pkg::REF_COUNT_MIN;
        end
        @(posedge core_clk_i);
        wr_o    <= 1'b1;
        addr_o  <= a;
        wdata_o <= d;
        @(posedge core_clk_i);
        wr_o <= 1'b0;
        #1;
    endtask
endmodule

// file: verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic        core_clk_i;
    logic        rst_i;
    logic        clk_en_i;
    logic        rd_i;
    logic        wr_i;
    logic [7:0]  addr_i;
    logic [15:0] wdata_i;
    logic [15:0] rdata_o;
    logic [15:0] rdata12;
    logic [3:0]  conv_done_i;
    logic [3:0]  wd_fault_i;
    logic [3:0]  aw_fault_i;
    logic [27:0] result_i [4];
    logic        chan0_conv_end_o;
    logic [15:0] chan0_ref_count_o;
    logic [15:0] v [4];
    logic [27:0] res;
    logic [1:0]  c;
    int          failures;
    int          checked;
    int          n;
    ccr_result_regs u_dut (.core_clk_i, .rst_i, .clk_en_i, .rd_i, .wr_i, .addr_i,
        .wdata_i, .rdata_o, .conv_done_i, .wd_fault_i, .aw_fault_i, .result_i,
        .chan0_conv_end_o, .chan0_ref_count_o);
    ccr_result_regs #(.VARIANT(ccr_pkg::VARIANT_12)) u_dut12 (.core_clk_i, .rst_i,
        .clk_en_i, .rd_i, .wr_i, .addr_i, .wdata_i, .rdata_o(rdata12), .conv_done_i,
        .wd_fault_i, .aw_fault_i, .result_i, .chan0_conv_end_o(), .chan0_ref_count_o());
    ccr_host_model u_host (.core_clk_i, .rdata_i(rdata_o), .rdata12_i(rdata12),
        .rd_o(rd_i), .wr_o(wr_i), .addr_o(addr_i), .wdata_o(wdata_i));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("checked=%0d failures=%0d", checked, failures);
        if (failures == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Counts edges up to the next interval pulse; bounded so a dead counter shows
    task automatic wait_end();
        for (int i = 0; i < 9000; i++) begin
            @(posedge core_clk_i);
            n = i + 1;
            if (chan0_conv_end_o === 1'b1) break;
        end
    endtask
    initial begin
        core_clk_i = 1'b0;
        forever #4 core_clk_i = ~core_clk_i;
    end
    initial begin
        #200us;
        failures++;
        end_sim();
    end
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        rst_i = 1'b1;
        clk_en_i = 1'b1;
        conv_done_i = 4'h0;
        wd_fault_i = 4'h0;
        aw_fault_i = 4'h0;
        result_i = '{default: 28'h0000000};
        failures = 0;
        checked = 0;
        repeat (16) @(posedge core_clk_i);
        rst_i <= 1'b0;
        u_host.rd(8'h08, v[0], v[1]);
        chk(v[0], 16'h0080);
        chk(chan0_ref_count_o, 16'h0080);
        for (int ch = 0; ch < 4; ch++) begin
            c = 2'(ch);
            res = 28'h0fedcba - 28'(ch) * 28'h0123457;
            @(posedge core_clk_i);
            result_i[ch] <= res;
            conv_done_i[ch] <= 1'b1;
            wd_fault_i[ch] <= c[0];
            aw_fault_i[ch] <= c[1];
            @(posedge core_clk_i);
            conv_done_i <= 4'h0;
            wd_fault_i <= 4'h0;
            aw_fault_i <= 4'h0;
            // Read-only lower half must ignore this
            u_host.wr(8'(2 * ch + 1), 16'h5a5a);
            u_host.rd_chan(8'(2 * ch), v);
            chk(v[0], {2'b00, c[0], c[1], res[27:16]});
            chk(v[1], {2'b00, c[0], c[1], res[11:0]});
            chk(v[2], res[15:0]);
            chk(v[3], 16'h0000);
            u_host.rd(8'(2 * ch), v[0], v[1]);
            chk(v[0], {4'h0, res[27:16]});
        end
        // Lower-half writes must not reach the interval
        chk(chan0_ref_count_o, 16'h0080);
        // Faults on channel 0, then a read while the clock enable is low
        @(posedge core_clk_i);
        wd_fault_i[0] <= 1'b1;
        aw_fault_i[0] <= 1'b1;
        @(posedge core_clk_i);
        wd_fault_i <= 4'h0;
        aw_fault_i <= 4'h0;
        clk_en_i <= 1'b0;
        u_host.rd(ccr_pkg::ADDR_CH0_UPPER, v[0], v[1]);
        chk(v[0], 16'h0000);
        chk(v[1], 16'h0000);
        @(posedge core_clk_i);
        clk_en_i <= 1'b1;
        // Fault in the very cycle of the read: the set wins
        fork
            u_host.rd(ccr_pkg::ADDR_CH0_UPPER, v[0], v[1]);
            begin
                @(posedge core_clk_i);
                wd_fault_i[0] <= 1'b1;
                @(posedge core_clk_i);
                wd_fault_i[0] <= 1'b0;
            end
        join
        chk(v[0], 16'h30fe);
        chk(v[1], 16'h3cba);
        u_host.rd(ccr_pkg::ADDR_CH0_UPPER, v[0], v[1]);
        chk(v[0], 16'h20fe);
        chk(v[1], 16'h2cba);
        u_host.rd(ccr_pkg::ADDR_CH0_UPPER, v[0], v[1]);
        chk(v[0], 16'h00fe);
        u_host.wr(8'h08, 16'h0100);
        chk(chan0_ref_count_o, 16'h0100);
        u_host.rd(ccr_pkg::ADDR_CH0_INTERVAL, v[0], v[1]);
        chk(v[0], 16'h0100);
        wait_end();
        wait_end();
        wait_end();
        chk(16'(n), 16'h1000);
        // Mid-run reset restores the interval and clears the results
        rst_i <= 1'b1;
        repeat (2) @(posedge core_clk_i);
        rst_i <= 1'b0;
        u_host.rd(ccr_pkg::ADDR_CH0_INTERVAL, v[0], v[1]);
        chk(v[0], 16'h0080);
        chk(chan0_ref_count_o, 16'h0080);
        u_host.rd(ccr_pkg::ADDR_CH0_UPPER, v[0], v[1]);
        chk(v[0], 16'h0000);
        end_sim();
    end
endmodule
